// File: bench/rdw_host_mem.sv
// Host memory model facing the engine's memory port: 1 KiB of words.
// Assumes requests are held until acknowledged; ack delay is random, 0 to 3 cycles.
`timescale 1ns/100ps
module rdw_host_mem (
    input wire logic i_clk, // Core clock
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_req, // Request from engine
    input wire rdw_pkg::rdw_mem_req_t i_mem, // Request payload
    output logic o_ack, // One-cycle acknowledge
    output logic [31:0] o_rdata // Read data with ack
);
    import rdw_pkg::*;
    logic [31:0] mem [0:255];
    int wait_q;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ack <= 1'b0;
            wait_q <= 0;
        end else if (i_req && !o_ack && wait_q == 0) begin
            o_ack <= 1'b1;
            wait_q <= $urandom_range(3, 0);
            o_rdata <= mem[i_mem.addr[9:2]];
            for (int k = 0; k < 4; k++) begin
                if (i_mem.we && i_mem.strb[k]) begin
                    mem[i_mem.addr[9:2]][8*k +: 8] <= i_mem.wdata[8*k +: 8];
                end
            end
        end else begin
            o_ack <= 1'b0;
            // Outside an ack the data is junk, so stale values cannot pass
            o_rdata <= $urandom;
            if (i_req && !o_ack) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule

// File: bench/receive_descriptor_writeback_test.sv
// Self-checking bench for the descriptor writeback engine.
// Assumes the host memory model and AXI4-Lite master tasks below stand in for the host.
`timescale 1ns/100ps
module receive_descriptor_writeback_test;
    import rdw_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic rx_valid = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    rdw_rx_beat_t rx = '0;
    logic awready, wready, bvalid, arready, rvalid, rx_ready, mem_req, mem_ack;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, mem_rdata;
    rdw_mem_req_t mem;
    logic [31:0] exp_mem[$];
    logic [34:0] exp_rd[$];
    logic [34:0] rd_e;
    logic [7:0] bq[$];
    int errors = 0, num_checks = 0, nwr = 0, n0 = 0;
    always #4 clk = ~clk;
    rdw_engine DUT (.i_core_clk(clk), .i_resetn(resetn), .i_awvalid(awvalid),
        .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
        .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .i_rx(rx), .o_mem_req(mem_req),
        .o_mem(mem), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata));
    rdw_host_mem u_mem (.i_clk(clk), .i_resetn(resetn), .i_req(mem_req), .i_mem(mem),
        .o_ack(mem_ack), .o_rdata(mem_rdata));
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Results are compared here, in the order they were noted
    always @(posedge clk) begin
        if (mem_req && mem_ack && mem.we) begin
            nwr++;
            if (mem.strb === RDW_STRB_LOW_HALF && exp_mem.size() == 0) begin
                errors++;
                $display("unexpected writeback: expected none seen %h", mem.wdata);
            end else if (mem.strb === RDW_STRB_LOW_HALF) begin
                check("writeback", exp_mem.pop_front(), {mem.addr[15:0], mem.wdata[15:0]});
            end
        end
        if (rvalid && rready) begin
            rd_e = exp_rd.pop_front();
            check("rresp", 32'(rd_e[33:32]), 32'(rresp));
            if (!rd_e[34]) begin
                check("rdata", rd_e[31:0], rdata);
            end
        end
    end
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        logic ga, gw;
        int t;
        ga = 1'b0;
        gw = 1'b0;
        t = 0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        while (!(ga && gw) && t < 1000) begin
            @(posedge clk);
            t++;
            if (awready) begin
                ga = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready) begin
                gw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (bvalid !== 1'b1 && t < 2000);
        check("bresp", 32'(a > RDW_REG_STATUS ? RDW_RESP_SLVERR : RDW_RESP_OKAY), 32'(bresp));
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axr(input logic [31:0] a, input logic [34:0] e);
        int t;
        t = 0;
        exp_rd.push_back(e);
        arvalid <= 1'b1;
        araddr <= a;
        do begin
            @(posedge clk);
            t++;
        end while (arready !== 1'b1 && t < 1000);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (rvalid !== 1'b1 && t < 2000);
        rready <= 1'b0;
        @(posedge clk);
    endtask
    // Software side of the list: status, EOF and count-valid cleared, format bit 0
    task automatic arm(input logic [31:0] d, input logic [31:0] cmd, input logic [31:0] lnk,
            input int size);
        u_mem.mem[d[9:2]] = cmd;
        u_mem.mem[d[9:2] + 1] = lnk;
        u_mem.mem[d[9:2] + 3] = 32'(size) << RDW_SIZE_LSB;
    endtask
    task automatic expect_fr(input logic [31:0] d, input int cnt, input logic ok,
            input logic ov, input logic er);
        exp_mem.push_back({16'(d + RDW_DESC_SIZE_OFF),
            (16'h1 << RDW_EOF_BIT) | (16'h1 << RDW_F_BIT) | 16'(cnt)});
        exp_mem.push_back({16'(d), (16'h1 << RDW_C_BIT) | (16'(ok) << RDW_OK_BIT)
            | (16'(ov) << RDW_NOSPACE_BIT) | (16'(er) << RDW_RXERR_BIT)});
    endtask
    task automatic send(input int n, input int erri);
        int t;
        logic [7:0] b;
        bq.delete();
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            bq.push_back(b);
            rx_valid <= 1'b1;
            rx <= '{data: b, last: (i == n - 1), err: (i == erri)};
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (rx_ready !== 1'b1 && t < 3000);
        end
        rx_valid <= 1'b0;
    endtask
    task automatic wait_done();
        int t;
        t = 0;
        while (exp_mem.size() != 0 && t < 3000) begin
            @(posedge clk);
            t++;
        end
        check("pending writebacks", 32'h0, 32'(exp_mem.size()));
        repeat (4) @(posedge clk);
    endtask
    task automatic chk_data(input logic [31:0] d, input int cnt);
        logic [31:0] a;
        for (int i = 0; i < cnt; i++) begin
            a = d + RDW_DESC_DATA_OFF + 32'(i);
            check("stored byte", 32'(bq[i]), 32'(u_mem.mem[a[9:2]][8*a[1:0] +: 8]));
        end
    endtask
    task automatic check_dropped(input int n);
        n0 = nwr;
        send(n, -1);
        repeat (20) @(posedge clk);
        check("memory writes", 32'(n0), 32'(nwr));
    endtask
    initial begin
        void'($urandom(30270));
        for (int i = 0; i < 256; i++) begin
            u_mem.mem[i] = 32'h0;
        end
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        axr(RDW_REG_CTRL, 35'h0);
        axr(RDW_REG_STATUS, 35'h0);
        axr(32'h0000_0010, {1'b1, RDW_RESP_SLVERR, 32'h0});
        axw(32'h0000_0010, 32'h0);
        axw(RDW_REG_CTRL, 32'h2);
        axr(RDW_REG_CTRL, {3'h0, 32'h2});
        arm(32'h100, 32'h1 << RDW_HDR_BIT, 32'h40, 8);
        arm(32'h140, 32'h0, 32'h80, 2);
        arm(32'h180, 32'h1 << RDW_EL_BIT, 32'h0, 4);
        axw(RDW_REG_BASE, 32'h100);
        axr(RDW_REG_BASE, {3'h0, 32'h100});
        axw(RDW_REG_FIRST, 32'h0);
        axw(RDW_REG_CTRL, 32'h1);
        expect_fr(32'h100, 8, 1'b1, 1'b0, 1'b0);
        send(8, -1);
        wait_done();
        chk_data(32'h100, 8);
        expect_fr(32'h140, 2, 1'b0, 1'b1, 1'b1);
        send(3, 1);
        wait_done();
        chk_data(32'h140, 2);
        check("byte past size", 32'h0, 32'(u_mem.mem[84][23:16]));
        expect_fr(32'h180, 4, 1'b1, 1'b0, 1'b0);
        send(4, -1);
        wait_done();
        chk_data(32'h180, 4);
        axr(RDW_REG_STATUS, {3'h0, 32'h1C});
        check_dropped(6);
        arm(32'h100, 32'h1 << RDW_SUSP_BIT, 32'h40, 8);
        arm(32'h140, 32'h0, 32'h80, 2);
        axw(RDW_REG_CTRL, 32'h1);
        expect_fr(32'h100, 6, 1'b1, 1'b0, 1'b0);
        send(6, -1);
        wait_done();
        axr(RDW_REG_STATUS, {3'h0, 32'h0D});
        check_dropped(3);
        axw(RDW_REG_CTRL, 32'h4);
        expect_fr(32'h140, 2, 1'b1, 1'b0, 1'b0);
        send(2, -1);
        wait_done();
        chk_data(32'h140, 2);
        finish_test();
    end
    initial begin
        #400000;
        errors++;
        $display("unexpected run time: expected end seen timeout at %0t", $time);
        finish_test();
    end
endmodule

// File: hdl/rdw_engine.sv
// Receive descriptor writeback engine: walks the free receive list in host
// memory, stores each frame after its descriptor and writes back status.
// Assumes the frame stream and memory port share i_core_clk.
`timescale 1ns/100ps
module rdw_engine (
    input wire logic i_core_clk, // Core clock, 125 MHz
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_awvalid, // AXI write address valid
    output logic o_awready, // AXI write address ready
    input wire logic [31:0] i_awaddr, // AXI write address
    input wire logic i_wvalid, // AXI write data valid
    output logic o_wready, // AXI write data ready
    input wire logic [31:0] i_wdata, // AXI write data
    input wire logic [3:0] i_wstrb, // AXI write strobes
    output logic o_bvalid, // AXI write response valid
    input wire logic i_bready, // AXI write response ready
    output logic [1:0] o_bresp, // AXI write response
    input wire logic i_arvalid, // AXI read address valid
    output logic o_arready, // AXI read address ready
    input wire logic [31:0] i_araddr, // AXI read address
    output logic o_rvalid, // AXI read data valid
    input wire logic i_rready, // AXI read data ready
    output logic [31:0] o_rdata, // AXI read data
    output logic [1:0] o_rresp, // AXI read response
    input wire logic i_rx_valid, // Frame byte valid
    output logic o_rx_ready, // Frame byte accepted
    input wire rdw_pkg::rdw_rx_beat_t i_rx, // Frame byte, last, error
    output logic o_mem_req, // Memory request, held until ack
    output rdw_pkg::rdw_mem_req_t o_mem, // Memory request payload
    input wire logic i_mem_ack, // Memory acknowledge pulse
    input wire logic [31:0] i_mem_rdata // Read data with ack
);
    import rdw_pkg::*;

    rdw_state_t state_q, state_d;
    logic [31:0] base_q, first_q, cur_q, next_q;
    logic hds_q, start_q, resume_q;
    logic el_q, susp_q, hdr_q;
    logic [RDW_CNT_W-1:0] size_q, count_q;
    logic ovf_q, err_q, last_q;
    logic mem_done, take_byte, wr_fire, b_clear, rd_take;
    logic aw_have_q, w_have_q;
    logic [31:0] aw_addr_q, w_data_q;
    logic [3:0] w_strb_q;
    logic frame_ok;

    assign mem_done = o_mem_req && i_mem_ack;
    assign take_byte = i_rx_valid && o_rx_ready && (state_q == RDW_RECV);
    assign frame_ok = !ovf_q && !err_q;

    // Register slave: address and data may come in either order
    assign wr_fire = aw_have_q && w_have_q && !o_bvalid;
    assign b_clear = o_bvalid && i_bready;
    assign rd_take = i_arvalid && o_arready;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= RDW_RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= i_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
            o_awready <= !aw_have_q && !(i_awvalid && o_awready) && !o_bvalid;
            o_wready <= !w_have_q && !(i_wvalid && o_wready) && !o_bvalid;
            if (wr_fire) begin
                o_bvalid <= 1'b1;
                if (aw_addr_q == RDW_REG_CTRL || aw_addr_q == RDW_REG_BASE ||
                    aw_addr_q == RDW_REG_FIRST || aw_addr_q == RDW_REG_STATUS) begin
                    o_bresp <= RDW_RESP_OKAY;
                end else begin
                    o_bresp <= RDW_RESP_SLVERR;
                end
            end else if (b_clear) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Control registers; start and resume are one-cycle pulses
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            base_q <= 32'h0000_0000;
            first_q <= 32'h0000_0000;
            hds_q <= 1'b0;
            start_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            resume_q <= 1'b0;
            if (wr_fire && w_strb_q[0]) begin
                if (aw_addr_q == RDW_REG_CTRL) begin
                    start_q <= w_data_q[RDW_CTRL_START];
                    resume_q <= w_data_q[RDW_CTRL_RESUME];
                    hds_q <= w_data_q[RDW_CTRL_HDS];
                end
            end
            if (wr_fire && aw_addr_q == RDW_REG_BASE) begin
                base_q <= w_data_q;
            end
            if (wr_fire && aw_addr_q == RDW_REG_FIRST) begin
                first_q <= w_data_q;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RDW_RESP_OKAY;
        end else begin
            o_arready <= !o_rvalid && !rd_take;
            if (rd_take) begin
                o_rvalid <= 1'b1;
                o_rresp <= RDW_RESP_OKAY;
                if (i_araddr == RDW_REG_CTRL) begin
                    o_rdata <= 32'(hds_q) << RDW_CTRL_HDS;
                end else if (i_araddr == RDW_REG_BASE) begin
                    o_rdata <= base_q;
                end else if (i_araddr == RDW_REG_FIRST) begin
                    o_rdata <= first_q;
                end else if (i_araddr == RDW_REG_STATUS) begin
                    // Header flag shown only while the HDS control bit (hds_q) is set
                    o_rdata <= {26'h0, hdr_q && hds_q, state_q == RDW_NORES,
                                state_q};
                end else begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= RDW_RESP_SLVERR;
                end
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // Descriptor walk
    always_comb begin
        state_d = state_q;
        case (state_q)
            RDW_IDLE, RDW_NORES, RDW_SUSP: begin
                if (start_q || (resume_q && state_q == RDW_SUSP)) begin
                    state_d = RDW_RD_CMD;
                end
            end
            RDW_RD_CMD: begin
                if (mem_done) state_d = RDW_RD_LINK;
            end
            RDW_RD_LINK: begin
                if (mem_done) state_d = RDW_RD_SIZE;
            end
            RDW_RD_SIZE: begin
                if (mem_done) state_d = RDW_RECV;
            end
            RDW_RECV: begin
                if (take_byte && count_q < size_q) begin
                    state_d = RDW_WR_BYTE;
                end else if (take_byte && i_rx.last) begin
                    state_d = RDW_WR_CNT;
                end
            end
            RDW_WR_BYTE: begin
                if (mem_done) state_d = last_q ? RDW_WR_CNT : RDW_RECV;
            end
            RDW_WR_CNT: begin
                if (mem_done) state_d = RDW_WR_STAT;
            end
            RDW_WR_STAT: begin
                if (mem_done) begin
                    if (el_q) begin
                        state_d = RDW_NORES;
                    end else if (susp_q) begin
                        state_d = RDW_SUSP;
                    end else begin
                        state_d = RDW_RD_CMD;
                    end
                end
            end
            default: state_d = RDW_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= RDW_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Ready only when a byte can go somewhere; idle states drop frames
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_ready <= 1'b0;
        end else begin
            o_rx_ready <= state_d == RDW_RECV || state_d == RDW_NORES ||
                          state_d == RDW_SUSP || state_d == RDW_IDLE;
        end
    end

    // Descriptor fields and frame bookkeeping
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cur_q <= 32'h0000_0000;
            next_q <= 32'h0000_0000;
            el_q <= 1'b0;
            susp_q <= 1'b0;
            hdr_q <= 1'b0;
            size_q <= '0;
        end else begin
            if (start_q && state_q != RDW_RECV) begin
                cur_q <= base_q + first_q;
            end else if (state_q == RDW_WR_STAT && mem_done) begin
                // Wraps naturally when the list is circular
                cur_q <= base_q + next_q;
            end
            if (state_q == RDW_RD_CMD && mem_done) begin
                el_q <= i_mem_rdata[RDW_EL_BIT];
                susp_q <= i_mem_rdata[RDW_SUSP_BIT];
                hdr_q <= i_mem_rdata[RDW_HDR_BIT];
            end
            if (state_q == RDW_RD_LINK && mem_done) begin
                next_q <= i_mem_rdata;
            end
            if (state_q == RDW_RD_SIZE && mem_done) begin
                // Header area already excluded from the size by software
                size_q <= i_mem_rdata[RDW_SIZE_LSB +: RDW_CNT_W];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count_q <= '0;
            ovf_q <= 1'b0;
            err_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            if (state_q == RDW_RD_SIZE) begin
                count_q <= '0;
                ovf_q <= 1'b0;
                err_q <= 1'b0;
                last_q <= 1'b0;
            end else if (take_byte) begin
                last_q <= i_rx.last;
                err_q <= err_q || i_rx.err;
                if (count_q == size_q) begin
                    ovf_q <= 1'b1;
                end
            end else if (state_q == RDW_WR_BYTE && mem_done) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // Memory request issue; payload fixed until the ack
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mem_req <= 1'b0;
            o_mem <= '0;
        end else begin
            if (mem_done) begin
                o_mem_req <= 1'b0;
            end
            if (state_d != state_q) begin
                case (state_d)
                    RDW_RD_CMD: begin
                        o_mem_req <= 1'b1;
                        o_mem <= '{1'b0, (start_q ? base_q + first_q :
                                  (state_q == RDW_WR_STAT ? base_q + next_q : cur_q)) +
                                  RDW_DESC_CMD_OFF, 32'h0, RDW_STRB_ALL};
                    end
                    RDW_RD_LINK: begin
                        o_mem_req <= 1'b1;
                        o_mem <= '{1'b0, cur_q + RDW_DESC_LINK_OFF, 32'h0, RDW_STRB_ALL};
                    end
                    RDW_RD_SIZE: begin
                        o_mem_req <= 1'b1;
                        o_mem <= '{1'b0, cur_q + RDW_DESC_SIZE_OFF, 32'h0, RDW_STRB_ALL};
                    end
                    RDW_WR_BYTE: begin
                        o_mem_req <= 1'b1;
                        o_mem.we <= 1'b1;
                        o_mem.addr <= cur_q + RDW_DESC_DATA_OFF + 32'(count_q);
                        o_mem.wdata <= {4{i_rx.data}};
                        o_mem.strb <= RDW_STRB_BYTE0 << (cur_q[1:0] + count_q[1:0]);
                    end
                    RDW_WR_CNT: begin
                        // Low half only, so the size field survives
                        o_mem_req <= 1'b1;
                        // Count bumps on this same edge after a byte write ack
                        o_mem <= '{1'b1, cur_q + RDW_DESC_SIZE_OFF,
                                  (32'h1 << RDW_EOF_BIT) | (32'h1 << RDW_F_BIT) |
                                  (32'(count_q) + 32'(state_q == RDW_WR_BYTE)),
                                  RDW_STRB_LOW_HALF};
                    end
                    RDW_WR_STAT: begin
                        // Command half left untouched
                        o_mem_req <= 1'b1;
                        o_mem <= '{1'b1, cur_q + RDW_DESC_CMD_OFF,
                                  (32'h1 << RDW_C_BIT) | (32'(frame_ok) << RDW_OK_BIT) |
                                  (32'(ovf_q) << RDW_NOSPACE_BIT) |
                                  (32'(err_q) << RDW_RXERR_BIT),
                                  RDW_STRB_LOW_HALF};
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    property p_stat_complete;
        state_q == RDW_WR_STAT && o_mem_req |-> o_mem.we && o_mem.wdata[RDW_C_BIT];
    endproperty
    a_stat_complete: assert property (p_stat_complete) else $error("C bit missing");

    property p_stat_ok;
        state_q == RDW_WR_STAT && o_mem_req |-> o_mem.wdata[RDW_OK_BIT] == (!ovf_q && !err_q);
    endproperty
    a_stat_ok: assert property (p_stat_ok) else $error("OK bit wrong");

    property p_stat_nospace;
        state_q == RDW_WR_STAT && o_mem_req |-> o_mem.wdata[RDW_NOSPACE_BIT] == ovf_q;
    endproperty
    a_stat_nospace: assert property (p_stat_nospace) else $error("Bit 9 wrong");

    property p_cnt_word;
        state_q == RDW_WR_CNT && o_mem_req |-> o_mem.wdata[RDW_CNT_W-1:0] == count_q &&
            o_mem.wdata[RDW_F_BIT] && o_mem.wdata[RDW_EOF_BIT] &&
            o_mem.addr == cur_q + RDW_DESC_SIZE_OFF;
    endproperty
    a_cnt_word: assert property (p_cnt_word) else $error("Count word wrong");

    property p_count_bound;
        count_q <= size_q;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("Count past size");

    property p_byte_addr;
        state_q == RDW_WR_BYTE && o_mem_req |->
            o_mem.addr == cur_q + RDW_DESC_DATA_OFF + 32'(count_q);
    endproperty
    a_byte_addr: assert property (p_byte_addr) else $error("Byte address wrong");

    property p_end_of_list;
        state_q == RDW_WR_STAT && mem_done && el_q |=> state_q == RDW_NORES ##1 o_rx_ready;
    endproperty
    a_end_of_list: assert property (p_end_of_list) else $error("No-resource missed");

    property p_suspend;
        state_q == RDW_WR_STAT && mem_done && !el_q && susp_q |=> state_q == RDW_SUSP;
    endproperty
    a_suspend: assert property (p_suspend) else $error("Suspend missed");

    property p_link;
        state_q == RDW_WR_STAT && mem_done && !el_q && !susp_q |=>
            state_q == RDW_RD_CMD && o_mem.addr == base_q + next_q;
    endproperty
    a_link: assert property (p_link) else $error("Link not followed");

    c_frame_ok: cover property (state_q == RDW_WR_STAT && mem_done && frame_ok);
    c_overflow: cover property (state_q == RDW_WR_STAT && mem_done && ovf_q);
    c_nores: cover property (state_q == RDW_NORES && i_rx_valid);
    c_suspend: cover property (state_q == RDW_SUSP ##1 state_q == RDW_RD_CMD);
endmodule

// File: hdl/rdw_pkg.sv
// Package for the receive descriptor writeback engine: descriptor layout,
// register map, bus encodings and carrier structs.
// Assumes host memory answers one word request at a time.
package rdw_pkg;
    // Descriptor word offsets in bytes
    localparam logic [31:0] RDW_DESC_CMD_OFF = 32'h0000_0000;
    localparam logic [31:0] RDW_DESC_LINK_OFF = 32'h0000_0004;
    localparam logic [31:0] RDW_DESC_SIZE_OFF = 32'h0000_000C;
    localparam logic [31:0] RDW_DESC_DATA_OFF = 32'h0000_0010;
    // Command half of word 0
    localparam int RDW_EL_BIT = 31;
    localparam int RDW_SUSP_BIT = 30;
    localparam int RDW_HDR_BIT = 20;
    localparam int RDW_SF_BIT = 19;
    // Status half of word 0
    localparam int RDW_C_BIT = 15;
    localparam int RDW_OK_BIT = 13;
    localparam int RDW_NOSPACE_BIT = 9;
    localparam int RDW_RXERR_BIT = 4;
    // Word 3 layout
    localparam int RDW_CNT_W = 14;
    localparam int RDW_F_BIT = 14;
    localparam int RDW_EOF_BIT = 15;
    localparam int RDW_SIZE_LSB = 16;
    localparam logic [3:0] RDW_STRB_LOW_HALF = 4'h3;
    localparam logic [3:0] RDW_STRB_ALL = 4'hF;
    localparam logic [3:0] RDW_STRB_BYTE0 = 4'h1;
    // Register map (byte addresses)
    localparam logic [31:0] RDW_REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] RDW_REG_BASE = 32'h0000_0004;
    localparam logic [31:0] RDW_REG_FIRST = 32'h0000_0008;
    localparam logic [31:0] RDW_REG_STATUS = 32'h0000_000C;
    localparam int RDW_CTRL_START = 0;
    localparam int RDW_CTRL_HDS = 1;
    localparam int RDW_CTRL_RESUME = 2;
    localparam logic [1:0] RDW_RESP_OKAY = 2'h0;
    localparam logic [1:0] RDW_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        RDW_IDLE = 4'h0,
        RDW_RD_CMD = 4'h1,
        RDW_RD_LINK = 4'h3,
        RDW_RD_SIZE = 4'h2,
        RDW_RECV = 4'h6,
        RDW_WR_BYTE = 4'h7,
        RDW_WR_CNT = 4'h5,
        RDW_WR_STAT = 4'h4,
        RDW_NORES = 4'hC,
        RDW_SUSP = 4'hD
    } rdw_state_t;

    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } rdw_mem_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic err;
    } rdw_rx_beat_t;
endpackage
